// ---- verilog/dio_bank_pkg.sv ----
// constants and helpers shared by the digital i/o port bank
package dio_bank_pkg;

   // ==========================================================
   // geometry
   localparam int GROUPS      = 4;
   localparam int GROUP_PINS  = 24;
   localparam int ADDR_W      = 5;

   // ==========================================================
   // register map (byte offsets)
   localparam logic [4:0] GROUP_STRIDE  = 5'h04;
   localparam logic [1:0] SLOT_PORT_A   = 2'h0;
   localparam logic [1:0] SLOT_PORT_B   = 2'h1;
   localparam logic [1:0] SLOT_PORT_C   = 2'h2;
   localparam logic [1:0] SLOT_CONTROL  = 2'h3;
   localparam logic [4:0] GROUP0_DIRECTION_CONTROL = 5'h03;
   localparam logic [4:0] GROUP1_DIRECTION_CONTROL = 5'h07;
   localparam logic [4:0] GROUP2_DIRECTION_CONTROL = 5'h0b;
   localparam logic [4:0] GROUP3_DIRECTION_CONTROL = 5'h0f;
   localparam logic [4:0] BOARD_IDENTIFIER         = 5'h14;

   // ==========================================================
   // control word bit positions (1 = input, 0 = output)
   localparam int CTL_PORT_A   = 4;
   localparam int CTL_PORT_C_HI = 3;
   localparam int CTL_PORT_B   = 1;
   localparam int CTL_PORT_C_LO = 0;

   // ==========================================================
   // values after reset
   localparam logic [3:0]  SW_DIR_RESET  = 4'hf;
   localparam logic [23:0] OUT_RESET     = 24'h000000;
   localparam logic [7:0]  RD_RESET      = 8'h00;

   // port order inside a nibble of direction: a, b, c low, c high
   function automatic logic [23:0] dir_to_oe(input logic [3:0] is_out);
      dir_to_oe = {{4{is_out[3]}}, {4{is_out[2]}},
                   {8{is_out[1]}}, {8{is_out[0]}}};
   endfunction

endpackage

// ---- verilog/dio_port_group.sv ----
// one emulated mode-0 peripheral interface group: ports a, b and c
`timescale 1ns/1ps
module dio_port_group (
   input  wire logic        mclk,
   input  wire logic        pwr_rst_n,
   input  wire logic        init_load,
   input  wire logic        ctrl_we,
   input  wire logic [2:0]  data_we,
   input  wire logic [7:0]  wr_data,
   input  wire logic [3:0]  out_strap,
   input  wire logic [23:0] pins_in,
   output logic      [23:0] pins_out_q,
   output logic      [23:0] pins_oe_q,
   output logic      [7:0]  rd_a,
   output logic      [7:0]  rd_b,
   output logic      [7:0]  rd_c
);
   import dio_bank_pkg::*;

   logic [3:0]  sw_in_q;
   logic [3:0]  sw_in_d;
   logic [23:0] pins_out_d;
   logic [23:0] pins_oe_d;
   logic [23:0] rd_all;

   // ==========================================================
   // direction and output latches
   always_comb begin
      sw_in_d    = sw_in_q;
      pins_out_d = pins_out_q;
      if (init_load) begin
         sw_in_d    = SW_DIR_RESET;
         pins_out_d = OUT_RESET;
      end else begin
         if (ctrl_we) begin
            sw_in_d = {wr_data[CTL_PORT_C_HI], wr_data[CTL_PORT_C_LO],
                       wr_data[CTL_PORT_B], wr_data[CTL_PORT_A]};
         end
         // the latch is loaded whatever the direction, so software
         // can preset a safe level before turning a port round
         if (data_we[0]) pins_out_d[7:0]   = wr_data;
         if (data_we[1]) pins_out_d[15:8]  = wr_data;
         if (data_we[2]) pins_out_d[23:16] = wr_data;
      end
      // strapped ports are outputs regardless of the control word
      pins_oe_d = dir_to_oe(~sw_in_d | out_strap);
   end

   // only a loss of power clears these; a hot reset is handled by
   // init_load so that the retention strap can keep the state
   always_ff @(posedge mclk or negedge pwr_rst_n) begin
      if (!pwr_rst_n) begin
         sw_in_q    <= SW_DIR_RESET;
         pins_out_q <= OUT_RESET;
         pins_oe_q  <= 24'h000000;
      end else begin
         sw_in_q    <= sw_in_d;
         pins_out_q <= pins_out_d;
         pins_oe_q  <= pins_oe_d;
      end
   end

   // ==========================================================
   // read back: driven value for outputs, pin level for inputs
   always_comb begin
      rd_all = (pins_oe_q & pins_out_q) | (~pins_oe_q & pins_in);
      rd_a   = rd_all[7:0];
      rd_b   = rd_all[15:8];
      rd_c   = rd_all[23:16];
   end

   // ==========================================================
   // checks
   a_strap_forces_out: assert property (
      @(posedge mclk) disable iff (!pwr_rst_n)
      out_strap[0] |=> pins_oe_q[7:0] == 8'hff)
      else $error("strapped port a is not an output");

   a_ctrl_sets_dir: assert property (
      @(posedge mclk) disable iff (!pwr_rst_n)
      ctrl_we && !init_load && !out_strap[1]
      |=> pins_oe_q[15:8] == {8{~$past(wr_data[CTL_PORT_B])}})
      else $error("port b direction does not follow control word");

   a_output_readback: assert property (
      @(posedge mclk) disable iff (!pwr_rst_n)
      data_we[0] && !init_load && !ctrl_we && pins_oe_q[0]
      |=> rd_a == $past(wr_data))
      else $error("output port a does not read back its latch");

   a_init_defaults: assert property (
      @(posedge mclk) disable iff (!pwr_rst_n)
      init_load |=> pins_out_q == OUT_RESET
                    && pins_oe_q == dir_to_oe($past(out_strap)))
      else $error("reset defaults not applied");

endmodule // dio_port_group

// ---- verilog/dio_port_bank.sv ----
// four-group, 96-pin mode-0 digital i/o bank with board identifier
`timescale 1ns/1ps
module dio_port_bank #(
   parameter int GROUP_COUNT = dio_bank_pkg::GROUPS
) (
   input  wire logic                          mclk,
   input  wire logic                          arst_n,
   input  wire logic                          pwr_rst_n,
   input  wire logic [dio_bank_pkg::ADDR_W-1:0] addr,
   input  wire logic                          wr_en,
   input  wire logic [7:0]                    wr_data,
   input  wire logic                          rd_en,
   output logic      [7:0]                    rd_data_q,
   input  wire logic [3:0]                    identifier_switch_bank,
   input  wire logic                          reset_retention_strap,
   input  wire logic [4*GROUP_COUNT-1:0]      port_output_strap,
   input  wire logic [24*GROUP_COUNT-1:0]     pins_in,
   output logic      [24*GROUP_COUNT-1:0]     pins_out,
   output logic      [24*GROUP_COUNT-1:0]     pins_oe
);
   import dio_bank_pkg::*;

   logic                     rst_pend_q;
   logic                     rst_pend_d;
   logic                     init_load;
   logic                     wr_ok;
   logic [7:0]               rd_data_d;
   logic [8*GROUP_COUNT-1:0] rd_a;
   logic [8*GROUP_COUNT-1:0] rd_b;
   logic [8*GROUP_COUNT-1:0] rd_c;

   // ==========================================================
   // hot reset tracking
   // while the hot reset is low (and its first cycle after) the
   // defaults are reloaded unless retention is strapped on
   // writes are refused until one edge after release, so a bus
   // cycle that straddles the hot reset cannot half-land
   always_comb begin
      rst_pend_d = 1'b0;
      init_load  = rst_pend_q & ~reset_retention_strap;
      wr_ok      = wr_en & ~rst_pend_q;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_pend_q <= 1'b1;
      end else begin
         rst_pend_q <= rst_pend_d;
      end
   end

   // ==========================================================
   // port groups
   for (genvar g = 0; g < GROUP_COUNT; g++) begin : grp
      logic [ADDR_W-1:0] base;
      logic              hit;
      logic              ctrl_we;
      logic [2:0]        data_we;

      always_comb begin
         base    = ADDR_W'(g * 4);
         hit     = wr_ok && addr[ADDR_W-1:2] == base[ADDR_W-1:2];
         ctrl_we = hit && addr[1:0] == SLOT_CONTROL;
         data_we = {hit && addr[1:0] == SLOT_PORT_C,
                    hit && addr[1:0] == SLOT_PORT_B,
                    hit && addr[1:0] == SLOT_PORT_A};
      end

      dio_port_group u_group (
         .mclk       (mclk),
         .pwr_rst_n  (pwr_rst_n),
         .init_load  (init_load),
         .ctrl_we    (ctrl_we),
         .data_we    (data_we),
         .wr_data    (wr_data),
         .out_strap  (port_output_strap[4*g +: 4]),
         .pins_in    (pins_in[24*g +: 24]),
         .pins_out_q (pins_out[24*g +: 24]),
         .pins_oe_q  (pins_oe[24*g +: 24]),
         .rd_a       (rd_a[8*g +: 8]),
         .rd_b       (rd_b[8*g +: 8]),
         .rd_c       (rd_c[8*g +: 8])
      );
   end

   // ==========================================================
   // register reads
   // control words are write-only and read as zero; holes in the
   // map answer zero too, so a probe never sees stale data
   always_comb begin
      rd_data_d = rd_data_q;
      if (rd_en) begin
         rd_data_d = RD_RESET;
         if (addr == BOARD_IDENTIFIER) begin
            // switch closed pulls its line low, so on reads as 0
            rd_data_d = {4'h0, identifier_switch_bank};
         end else begin
            for (int g = 0; g < GROUP_COUNT; g++) begin
               if (addr[ADDR_W-1:2] == 3'(g)) begin
                  unique case (addr[1:0])
                     SLOT_PORT_A:  rd_data_d = rd_a[8*g +: 8];
                     SLOT_PORT_B:  rd_data_d = rd_b[8*g +: 8];
                     SLOT_PORT_C:  rd_data_d = rd_c[8*g +: 8];
                     SLOT_CONTROL: rd_data_d = RD_RESET;
                  endcase
               end
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data_q <= RD_RESET;
      end else begin
         rd_data_q <= rd_data_d;
      end
   end

   // ==========================================================
   // checks
   sequence s_hot_reset_held;
      !arst_n && reset_retention_strap;
   endsequence

   a_identifier_read: assert property (
      @(posedge mclk) disable iff (!arst_n)
      rd_en && addr == BOARD_IDENTIFIER
      |=> rd_data_q == {4'h0, $past(identifier_switch_bank)})
      else $error("identifier register read wrong");

   a_control_wo: assert property (
      @(posedge mclk) disable iff (!arst_n)
      rd_en && addr == GROUP2_DIRECTION_CONTROL |=> rd_data_q == 8'h00)
      else $error("control register did not read as zero");

   a_retain_hold: assert property (
      @(posedge mclk) disable iff (!pwr_rst_n)
      s_hot_reset_held ##1 s_hot_reset_held
      |-> $stable(pins_out) && $stable(pins_oe))
      else $error("retained state changed during hot reset");

   a_default_reload: assert property (
      @(posedge mclk) disable iff (!pwr_rst_n)
      !arst_n && !reset_retention_strap ##1 !arst_n
      |-> pins_out == '0)
      else $error("outputs not low during non-retained reset");

   // power released while the hot reset still holds the bus off;
   // from here the state owes nothing to what went before
   sequence s_power_release;
      !pwr_rst_n ##1 pwr_rst_n && rst_pend_q;
   endsequence

   // hot reset held two edges with retention off and power good
   sequence s_hot_default;
      pwr_rst_n && !arst_n && !reset_retention_strap
      ##1 pwr_rst_n && !arst_n;
   endsequence

   sequence s_ctrl_write(logic [ADDR_W-1:0] reg_addr);
      wr_en && !rst_pend_q && addr == reg_addr;
   endsequence

   a_unmapped_read: assert property (
      @(posedge mclk) disable iff (!arst_n)
      rd_en && int'(addr[ADDR_W-1:2]) >= GROUP_COUNT
      && addr != BOARD_IDENTIFIER |=> rd_data_q == RD_RESET)
      else $error("unmapped register did not read as zero");

   a_identifier_write: assert property (
      @(posedge mclk) disable iff (!arst_n)
      wr_en && !rst_pend_q && addr == BOARD_IDENTIFIER
      |=> $stable(pins_out) && $stable(pins_oe))
      else $error("identifier write disturbed the ports");

   // per-group checks; the strap jumpers are expected to stay put
   // while the board is powered, so they are read live here
   for (genvar g = 0; g < GROUP_COUNT; g++) begin : grp_chk
      a_power_defaults: assert property (
         @(posedge mclk)
         s_power_release |=> pins_out[24*g +: 24] == 24'h000000
         && pins_oe[24*g +: 24] == dir_to_oe(port_output_strap[4*g +: 4]))
         else $error("power-on port defaults not applied");

      a_hot_default_dir: assert property (
         @(posedge mclk)
         s_hot_default |-> pins_oe[24*g +: 24]
         == dir_to_oe(port_output_strap[4*g +: 4]))
         else $error("hot reset left a software port driving");

      a_ctrl_output_drives: assert property (
         @(posedge mclk) disable iff (!arst_n)
         s_ctrl_write(ADDR_W'(4*g + 3))
         |=> pins_out[24*g +: 24] == $past(pins_out[24*g +: 24])
         && pins_oe[24*g +: 24] == dir_to_oe(port_output_strap[4*g +: 4]
            | ~{$past(wr_data[CTL_PORT_C_HI]), $past(wr_data[CTL_PORT_C_LO]),
                $past(wr_data[CTL_PORT_B]), $past(wr_data[CTL_PORT_A])}))
         else $error("control write did not turn the ports round");

      a_port_a_readback: assert property (
         @(posedge mclk) disable iff (!arst_n)
         rd_en && addr == ADDR_W'(4*g) && pins_oe[24*g]
         |=> rd_data_q == $past(pins_out[24*g +: 8]))
         else $error("output port a did not read back its latch");
   end

endmodule // dio_port_bank

// ---- tb/pin_env.sv ----
// pin-side environment of the port bank: pull-ups and an external driver
`timescale 1ns/1ps
module pin_env (
   input  wire logic [95:0] pins_out,
   input  wire logic [95:0] pins_oe,
   input  wire logic        ext_en,
   input  wire logic [95:0] ext_val,
   output logic      [95:0] pins_in
);
   // ==========================================================
   // wire level
   // the bank drives first, then the external driver; a pin that neither drives floats to its pull-up
   always_comb begin
      for (int i = 0; i < 96; i++) begin
         if (pins_oe[i])
            pins_in[i] = pins_out[i];
         else if (ext_en)
            pins_in[i] = ext_val[i];
         else
            pins_in[i] = 1'b1;
      end
   end
endmodule // pin_env

// ---- tb/tb.sv ----
// self-checking bench for the four-group digital i/o port bank
`timescale 1ns/1ps
module tb;
   import dio_bank_pkg::*;
   logic        mclk = 0, arst_n = 0, pwr_rst_n = 0;
   logic [4:0]  addr = 5'h00;
   logic        wr_en = 0, rd_en = 0, reset_retention_strap = 0, ext_en = 0;
   logic [7:0]  wr_data = 8'h00, rd_data_q;
   logic [3:0]  identifier_switch_bank = 4'h0;
   logic [15:0] port_output_strap = 16'h0201;
   logic [95:0] pins_in, pins_out, pins_oe;
   logic [95:0] ext_val = {4{24'h0ff00f}};
   int          n_fail = 0, check_count = 0;
   int          pos[4] = '{4, 1, 0, 3};

   always #12.5 mclk = ~mclk;

   dio_port_bank dut_u (.mclk(mclk), .arst_n(arst_n), .pwr_rst_n(pwr_rst_n),
      .addr(addr), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en),
      .rd_data_q(rd_data_q), .identifier_switch_bank(identifier_switch_bank),
      .reset_retention_strap(reset_retention_strap),
      .port_output_strap(port_output_strap), .pins_in(pins_in),
      .pins_out(pins_out), .pins_oe(pins_oe));
   pin_env env_u (.pins_out(pins_out), .pins_oe(pins_oe), .ext_en(ext_en),
      .ext_val(ext_val), .pins_in(pins_in));

   // ==========================================================
   // helpers
   function automatic logic [23:0] oe24(input logic a, b, cl, ch);
      oe24 = {{4{ch}}, {4{cl}}, {8{b}}, {8{a}}};
   endfunction
   task automatic chk(input string nm, input logic [23:0] e, g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_grp(input int g, input logic [23:0] eo, ed);
      chk($sformatf("group%0d oe", g), eo, pins_oe[24*g +: 24]);
      chk($sformatf("group%0d out", g), ed, pins_out[24*g +: 24]);
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge mclk);
      #2;
      addr = a;
      wr_data = d;
      wr_en = 1;
      @(posedge mclk);
      #2;
      wr_en = 0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      @(posedge mclk);
      #2;
      addr = a;
      rd_en = 1;
      @(posedge mclk);
      #2;
      rd_en = 0;
      chk($sformatf("read %h", a), {16'h0000, e}, {16'h0000, rd_data_q});
   endtask
   // power-on reset also pulls the hot reset, as the bank expects
   task automatic rst(input logic pwr, input logic ret);
      @(posedge mclk);
      #2;
      reset_retention_strap = ret;
      arst_n = 0;
      pwr_rst_n = ~pwr;
      repeat (4) @(posedge mclk);
      #2;
      arst_n = 1;
      pwr_rst_n = 1;
      repeat (2) @(posedge mclk);
      #2;
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ==========================================================
   // tests
   initial begin
      rst(1, 0);
      chk_grp(0, oe24(1, 0, 0, 0), 24'h000000);
      chk_grp(2, oe24(0, 1, 0, 0), 24'h000000);
      rd(5'h01, 8'hff);
      rd(5'h00, 8'h00);
      wr(5'h00, 8'h3c);
      rd(5'h00, 8'h3c);
      $display("test reset defaults done");
      for (int i = 0; i < 16; i++) begin
         identifier_switch_bank = 4'(i);
         rd(5'h14, {4'h0, 4'(i)});
      end
      wr(5'h14, 8'hff);
      rd(5'h14, 8'h0f);
      $display("test identifier done");
      wr(5'h04, 8'h5a);
      wr(5'h05, 8'hc3);
      wr(5'h06, 8'h96);
      for (int k = 0; k < 4; k++) begin
         wr(5'h07, 8'hff ^ (8'h01 << pos[k]));
         chk("dir", oe24(k == 0, k == 1, k == 2, k == 3), pins_oe[47:24]);
      end
      wr(5'h07, 8'h24);
      chk_grp(1, 24'hffffff, 24'h96c35a);
      rd(5'h06, 8'h96);
      rd(5'h1f, 8'h00);
      rd(5'h0b, 8'h00);
      ext_en = 1;
      wr(5'h07, 8'hff);
      rd(5'h05, 8'hf0);
      wr(5'h07, 8'h24);
      $display("test direction done");
      wr(5'h0b, 8'hff);
      wr(5'h09, 8'h81);
      chk_grp(2, oe24(0, 1, 0, 0), 24'h008100);
      $display("test strap done");
      rst(0, 1);
      chk_grp(1, 24'hffffff, 24'h96c35a);
      chk_grp(2, oe24(0, 1, 0, 0), 24'h008100);
      rst(1, 1);
      chk_grp(1, 24'h000000, 24'h000000);
      chk_grp(2, oe24(0, 1, 0, 0), 24'h000000);
      wr(5'h07, 8'h00);
      wr(5'h09, 8'h81);
      rst(0, 0);
      chk_grp(1, 24'h000000, 24'h000000);
      chk_grp(2, oe24(0, 1, 0, 0), 24'h000000);
      $display("test retention done");
      report_and_stop();
   end

   // the whole run needs well under 20 us
   initial begin
      #200us;
      n_fail++;
      report_and_stop();
   end
endmodule // tb
